/* inc/burner_input_supervisor_regs.vh */
// constants for the burner input supervisor: offsets, fields, resets, timing
// assumes byte addresses on an 8-bit wishbone address, 32-bit data
`ifndef BURNER_INPUT_SUPERVISOR_REGS_VH
`define BURNER_INPUT_SUPERVISOR_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADR_CFG        8'h00
`define ADR_MSG_DLY    8'h04
`define ADR_REACT      8'h08
`define ADR_GAS_LIM    8'h0C
`define ADR_STATUS     8'h10
`define ADR_CAUSE      8'h14

// ----------------------------------------------------------------
// configuration fields (lsb positions)
// ----------------------------------------------------------------
`define F_CPI          0
`define F_START2       2
`define F_GAS_LOW      5
`define F_GAS_HIGH     7
`define F_OIL_LOW      8
`define F_OIL_HIGH     10
`define F_OIL_PERMIT   11

// closed-contact check modes
`define CPI_OFF        2'h0
`define CPI_GAS        2'h1
`define CPI_GAS_OIL    2'h2
`define CPI_OIL        2'h3
// second input modes
`define S2_OFF         3'h0
`define S2_PERMIT      3'h1
`define S2_CPI_GAS     3'h2
`define S2_CPI_GAS_OIL 3'h3
`define S2_CPI_OIL     3'h4
// gas low check modes
`define GL_ACT         2'h0
`define GL_DEACT_XOGP  2'h1
`define GL_DEACT       2'h2
// oil low check modes
`define OL_ACT         2'h0
`define OL_FROM_TS     2'h1
`define OL_DEACT       2'h2
// oil permit modes
`define OP_ACT         2'h0
`define OP_DEACT       2'h1
`define OP_REDUND      2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CFG        32'h0000_0000
`define RST_MSG_DLY    16'h0000
`define RST_REACT      16'h0014
`define RST_GAS_LIM    16'h012C

// ----------------------------------------------------------------
// sequence phases
// ----------------------------------------------------------------
`define PH_STANDBY     8'h0C
`define PH_PERMIT      8'h15
`define PH_CLOSE_END1  8'h26
`define PH_HEAVY_OIL_GAS_PILOT_PREIGN 8'h2C
`define PH_OPEN_A      8'h36
`define PH_OPEN_B      8'h3C
`define PH_CLOSE_BEG2  8'h48
`define PH_CLOSE_END2  8'h4E

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ        100
`define TICK_MS        10
`define TICK_CYCLES    (`TICK_MS * `CLK_MHZ * 1000)
`define REACT_MIN_MS   200
`define REACT_MIN_TICKS ((`REACT_MIN_MS + `TICK_MS - 1) / `TICK_MS)

`endif

/* hdl/hold_timer.v */
// tick-based hold timer: flags expiry once a condition has held long enough
// assumes tick is a one-cycle pulse in the clk_sys domain
`timescale 1ns/100ps
`default_nettype none

module hold_timer #(
  parameter W = 16
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst,
  // timing control
  input  wire         tick,
  input  wire         run,
  input  wire [W-1:0] limit,
  // result
  output reg          expired_q
);

  reg [W-1:0] cnt_q;

  // counter saturates so a long hold never wraps back to not expired
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q     <= {W{1'b0}};
      expired_q <= 1'b0;
    end else if (!run) begin
      cnt_q     <= {W{1'b0}};
      expired_q <= 1'b0;
    end else begin
      if (tick && (cnt_q != {W{1'b1}}))
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      expired_q <= (cnt_q >= limit);
    end
  end

endmodule // hold_timer

`default_nettype wire

/* hdl/burner_input_supervisor.v */
// burner input supervisor: safety input checks against phase and fuel
// assumes phase and status strobes come from the sequencer on clk_sys;
// contact and switch pins are asynchronous and are synchronised here
//
// Function
// - oil valve contact, oil firing: closed 12-38, 72-78, open 54, 60.
// - oil valve contact, gas firing: closed 12-38, 54, 60, 72-78.
// - contact open in standby blocks start and raises a message.
// - start block message delayed by a configurable time.
// - gas valve contact checked on both fuels with swapped patterns.
// - gas+oil contact uses the open 54/60 pattern on both fuels.
// - second input: off, gas permit, or any contact check mode.
// - gas low pressure evaluated on gas or gas pilot from phase 21.
// - missing gas pressure starts shortage; loss shuts burner down.
// - gas low check: active, off for gas pilot programs, or off.
// - pressure loss in safety time reacts after configurable delay.
// - gas start permit evaluated like gas low; loss shuts down.
// - gas high pressure from first safety time gives safety shutdown.
// - standard oil low expects pressure in preignition, else safety.
// - oil low from safety time ignores preignition.
// - oil high pressure on oil firing gives safety shutdown.
// - oil start permit on oil from phase 21; loss shuts down.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "burner_input_supervisor_regs.vh"

module burner_input_supervisor #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter TICK_W      = 20
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // sequencer state
  input  wire [7:0]  phase,
  input  wire        fuel_gas,
  input  wire        gas_pilot,
  input  wire        heavy_oil,
  input  wire        preignition,
  input  wire        first_safety_started,
  input  wire        safety_time,
  input  wire        second_safety_done,
  // contact and switch pins
  input  wire        valve_closed_contact,
  input  wire        second_contact,
  input  wire        gas_low_ok,
  input  wire        gas_high_trip,
  input  wire        oil_low_ok,
  input  wire        oil_high_trip,
  input  wire        oil_start_permit,
  input  wire        flame_contact,
  // reactions
  output reg         start_block_q,
  output reg         start_block_msg_q,
  output reg         shutdown_q,
  output reg         safety_shutdown_q,
  output reg         gas_shortage_q
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // returns {fault, standby_open} for one closed-contact input
  function [1:0] cpi_eval;
    input [1:0] mode;
    input       gas;
    input [7:0] ph;
    input       closed;
    reg         pat_open;
    reg         closed_ph;
    reg         open_ph;
    reg         stby;
    begin
      pat_open  = (mode == `CPI_GAS_OIL) ||
                  ((mode == `CPI_GAS) && gas) ||
                  ((mode == `CPI_OIL) && !gas);
      closed_ph = ((ph >= `PH_STANDBY) && (ph <= `PH_CLOSE_END1)) ||
                  ((ph >= `PH_CLOSE_BEG2) && (ph <= `PH_CLOSE_END2));
      open_ph   = (ph == `PH_OPEN_A) || (ph == `PH_OPEN_B);
      stby      = (ph == `PH_STANDBY);
      if (mode == `CPI_OFF) begin
        cpi_eval = 2'h0;
      end else begin
        cpi_eval[0] = stby && !closed;
        // other patterns want the contact closed in 54/60 too
        cpi_eval[1] = !stby && ((closed_ph && !closed) ||
                      (open_ph && (pat_open ? closed : !closed)));
      end
    end
  endfunction

  // byte-lane merge for register writes
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0]  sel;
    integer      i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i])
          lane_merge[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [7:0] pins_raw = {flame_contact, oil_start_permit, oil_high_trip,
                         oil_low_ok, gas_high_trip, gas_low_ok,
                         second_contact, valve_closed_contact};
  reg  [7:0] pins_meta_q;
  reg  [7:0] pins_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins_meta_q <= 8'h00;
      pins_q      <= 8'h00;
    end else begin
      pins_meta_q <= pins_raw;
      pins_q      <= pins_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // tick prescaler
  // ----------------------------------------------------------------
  localparam integer      TICK_LAST_I = TICK_CYCLES - 1;
  localparam [TICK_W-1:0] TICK_LAST   = TICK_LAST_I[TICK_W-1:0];
  reg [TICK_W-1:0] tick_cnt_q;
  reg              tick_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= {TICK_W{1'b0}};
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? {TICK_W{1'b0}} :
                    tick_cnt_q + {{(TICK_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [31:0] cfg_q;
  reg  [15:0] msg_dly_q;
  reg  [15:0] react_q;
  reg  [15:0] gas_lim_q;
  reg  [9:0]  cause_q;
  reg  [9:0]  event_c;

  wire [1:0] cpi_mode  = cfg_q[`F_CPI +: 2];
  wire [2:0] s2_mode   = cfg_q[`F_START2 +: 3];
  wire [1:0] gl_mode   = cfg_q[`F_GAS_LOW +: 2];
  wire       gh_en     = cfg_q[`F_GAS_HIGH];
  wire [1:0] ol_mode   = cfg_q[`F_OIL_LOW +: 2];
  wire       oh_en     = cfg_q[`F_OIL_HIGH];
  wire [1:0] op_mode   = cfg_q[`F_OIL_PERMIT +: 2];

  wire       wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wb_wr     = wb_req && wb_we_i;
  wire [31:0] cfg_new  = lane_merge(cfg_q, wb_dat_i, wb_sel_i);
  wire [31:0] w16_new  = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  wire [31:0] dly_new  = lane_merge({16'h0000, msg_dly_q}, wb_dat_i, wb_sel_i);
  wire [15:0] w1c_mask = (wb_wr && (wb_adr_i == `ADR_CAUSE)) ?
                         w16_new[15:0] : 16'h0000;

  reg [31:0] rd_c;
  always @* begin
    case (wb_adr_i)
      `ADR_CFG:     rd_c = cfg_q;
      `ADR_MSG_DLY: rd_c = {16'h0000, msg_dly_q};
      `ADR_REACT:   rd_c = {16'h0000, react_q};
      `ADR_GAS_LIM: rd_c = {16'h0000, gas_lim_q};
      `ADR_STATUS:  rd_c = {16'h0000, pins_q, 3'h0, gas_shortage_q,
                            safety_shutdown_q, shutdown_q,
                            start_block_msg_q, start_block_q};
      `ADR_CAUSE:   rd_c = {22'h00_0000, cause_q};
      default:      rd_c = 32'h0000_0000;
    endcase
  end

  // unmapped reads return zero and writes are dropped, still acked
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      cfg_q     <= `RST_CFG;
      msg_dly_q <= `RST_MSG_DLY;
      react_q   <= `RST_REACT;
      gas_lim_q <= `RST_GAS_LIM;
      cause_q   <= 10'h000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= rd_c;
      if (wb_wr) begin
        case (wb_adr_i)
          `ADR_CFG:     cfg_q     <= cfg_new;
          `ADR_MSG_DLY: msg_dly_q <= dly_new[15:0];
          `ADR_REACT:   react_q   <= w16_new[15:0];
          `ADR_GAS_LIM: gas_lim_q <= w16_new[15:0];
          default:      ;
        endcase
      end
      // a new event in the clearing cycle stays set
      cause_q <= (cause_q & ~w1c_mask[9:0]) | event_c;
    end
  end

  // ----------------------------------------------------------------
  // input evaluation
  // ----------------------------------------------------------------
  wire       fire_oil   = !fuel_gas;
  wire       at_permit  = (phase == `PH_PERMIT);
  wire       past_perm  = (phase > `PH_PERMIT);
  wire       from_perm  = (phase >= `PH_PERMIT);
  wire [1:0] s2_cpi     = (s2_mode == `S2_CPI_GAS)     ? `CPI_GAS :
                          (s2_mode == `S2_CPI_GAS_OIL) ? `CPI_GAS_OIL :
                          (s2_mode == `S2_CPI_OIL)     ? `CPI_OIL :
                          `CPI_OFF;
  wire [1:0] cpi_a      = cpi_eval(cpi_mode, fuel_gas, phase, pins_q[0]);
  wire [1:0] cpi_b      = cpi_eval(s2_cpi, fuel_gas, phase, pins_q[1]);

  // gas window closes at the end of the second safety time
  wire gas_win   = from_perm && !second_safety_done &&
                   (fuel_gas || gas_pilot);
  wire gl_on     = gas_win && (gl_mode != `GL_DEACT) &&
                   (fuel_gas || (gl_mode == `GL_ACT));
  wire gl_miss   = gl_on && !pins_q[2];
  wire gp_lost   = gas_win && (s2_mode == `S2_PERMIT) && !pins_q[1];
  wire gh_trip   = gh_en && fuel_gas && first_safety_started &&
                   pins_q[3];

  wire ol_win    = (ol_mode == `OL_ACT) ?
                   (preignition || first_safety_started ||
                    (heavy_oil && gas_pilot &&
                     (phase == `PH_HEAVY_OIL_GAS_PILOT_PREIGN))) :
                   (ol_mode == `OL_FROM_TS) && first_safety_started;
  wire ol_miss   = fire_oil && ol_win && !pins_q[4];
  wire oh_trip   = oh_en && fire_oil && pins_q[5];
  wire op_lost   = (op_mode == `OP_ACT) && fire_oil && from_perm &&
                   !pins_q[6];
  // relies on the redundancy contact being wired inverse
  wire red_fault = (op_mode == `OP_REDUND) &&
                   (pins_q[6] == pins_q[7]);

  // ----------------------------------------------------------------
  // delays
  // ----------------------------------------------------------------
  // reaction time clamped to 0.2 s .. gas safety time limit
  wire [31:0] react_mw  = `REACT_MIN_TICKS;
  wire [15:0] react_min = react_mw[15:0];
  wire [15:0] react_cap = (react_q > gas_lim_q) ? gas_lim_q : react_q;
  wire [15:0] react_lim = (react_cap < react_min) ? react_min :
                          react_cap;
  wire gl_exp;
  wire ol_exp;
  wire msg_exp;

  hold_timer #(.W(16)) u_gas_react (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .tick      (tick_q),
    .run       (gl_miss && past_perm && safety_time),
    .limit     (react_lim),
    .expired_q (gl_exp)
  );

  hold_timer #(.W(16)) u_oil_react (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .tick      (tick_q),
    .run       (ol_miss && safety_time),
    .limit     (react_lim),
    .expired_q (ol_exp)
  );

  // message only; the start block itself is never delayed
  hold_timer #(.W(16)) u_msg_delay (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .tick      (tick_q),
    .run       (cpi_a[0] || cpi_b[0]),
    .limit     (msg_dly_q),
    .expired_q (msg_exp)
  );

  // pressure shocks in safety time are ridden through
  wire gl_lost  = gl_miss && past_perm && (!safety_time || gl_exp);
  wire ol_fail  = ol_miss && (!safety_time || ol_exp);
  wire shortage = gl_miss && at_permit;
  wire cpi_flt  = cpi_a[1] || cpi_b[1];
  wire stby_opn = cpi_a[0] || cpi_b[0];

  always @* begin
    event_c = {red_fault, op_lost, oh_trip, ol_fail, gh_trip, gp_lost,
               gl_lost, shortage, cpi_flt, stby_opn};
  end

  // ----------------------------------------------------------------
  // reaction outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_block_q     <= 1'b0;
      start_block_msg_q <= 1'b0;
      shutdown_q        <= 1'b0;
      safety_shutdown_q <= 1'b0;
      gas_shortage_q    <= 1'b0;
    end else begin
      start_block_q     <= stby_opn;
      start_block_msg_q <= stby_opn && msg_exp;
      shutdown_q        <= gl_lost || gp_lost || op_lost;
      safety_shutdown_q <= cpi_flt || gh_trip || ol_fail ||
                           oh_trip || red_fault;
      gas_shortage_q    <= shortage;
    end
  end

endmodule // burner_input_supervisor

`default_nettype wire

/* verification/burner_input_monitor.sv */
// checker for burner input supervisor reactions and bus answer
// assumes config words are written with all byte lanes enabled
`timescale 1ns/100ps
`default_nettype none
`include "burner_input_supervisor_regs.vh"

module burner_input_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // sequencer
  input wire logic [7:0]  phase,
  input wire logic        fuel_gas,
  input wire logic        preignition,
  input wire logic        first_safety_started,
  input wire logic        safety_time,
  input wire logic        second_safety_done,
  // pins
  input wire logic        valve_closed_contact,
  input wire logic        gas_low_ok,
  input wire logic        gas_high_trip,
  input wire logic        oil_low_ok,
  input wire logic        oil_high_trip,
  input wire logic        oil_start_permit,
  input wire logic        flame_contact,
  // reactions
  input wire logic        start_block_q,
  input wire logic        start_block_msg_q,
  input wire logic        safety_shutdown_q,
  input wire logic        gas_shortage_q
);
  // ----
  // snooped registers, one cycle behind the slave
  // ----
  logic [31:0] cfg_q;
  logic [15:0] dly_q;
  logic        wr;
  logic        open_x;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign open_x = (cfg_q[1:0] == `CPI_GAS_OIL) || (cfg_q[1:0] == `CPI_GAS && fuel_gas)
                  || (cfg_q[1:0] == `CPI_OIL && !fuel_gas);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_q <= `RST_CFG;
      dly_q <= `RST_MSG_DLY;
    end else if (wr && wb_adr_i == `ADR_CFG) begin
      cfg_q <= wb_dat_i;
    end else if (wr && wb_adr_i == `ADR_MSG_DLY) begin
      dly_q <= wb_dat_i[15:0];
    end
  end
  // ----
  // assertions, 4-cycle hold covers 2 sync stages and output flop
  // ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_ACK_ONCE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single pulse");
  AST_STBY_OPEN: assert property ((cfg_q[1:0] != `CPI_OFF && phase == `PH_STANDBY
    && !valve_closed_contact) [*4] |-> start_block_q) else $error("standby open not blocked");
  AST_OPEN_PH: assert property ((cfg_q[1:0] != `CPI_OFF && valve_closed_contact == open_x
    && (phase == `PH_OPEN_A || phase == `PH_OPEN_B)) [*4] |-> safety_shutdown_q)
    else $error("wrong contact state in open phase ignored");
  AST_MSG_WAIT: assert property ($rose(start_block_q) && dly_q >= 16'h0002
    |-> !start_block_msg_q [*8]) else $error("start block message too early");
  AST_GAS_SHORT: assert property ((cfg_q[6:5] == `GL_ACT && fuel_gas && phase == `PH_PERMIT
    && !second_safety_done && !safety_time && !gas_low_ok) [*4] |-> gas_shortage_q)
    else $error("gas shortage not raised");
  AST_GAS_HIGH: assert property ((cfg_q[`F_GAS_HIGH] && fuel_gas && first_safety_started
    && gas_high_trip) [*4] |-> safety_shutdown_q) else $error("gas high ignored");
  AST_OIL_LOW: assert property ((cfg_q[9:8] == `OL_ACT && !fuel_gas && preignition
    && !safety_time && !oil_low_ok) [*4] |-> safety_shutdown_q) else $error("oil low ignored");
  AST_OIL_HIGH: assert property ((cfg_q[`F_OIL_HIGH] && !fuel_gas && oil_high_trip) [*4]
    |-> safety_shutdown_q) else $error("oil high ignored");
  AST_REDUND: assert property ((cfg_q[12:11] == `OP_REDUND
    && oil_start_permit == flame_contact) [*4] |-> safety_shutdown_q)
    else $error("equal redundancy contacts ignored");
  cover property ($rose(start_block_msg_q));
  cover property ($rose(gas_shortage_q));
  cover property ($rose(safety_shutdown_q));
endmodule // burner_input_monitor

bind burner_input_supervisor burner_input_monitor u_mon (.*);
`default_nettype wire

/* verification/pin_field_model.sv */
// model of the field switches and contacts wired to the supervisor
// assumes commanded states come from the bench on clk_sys edges
`timescale 1ns/100ps
`default_nettype none

module pin_field_model (
  // commanded switch states
  input  wire logic valve_shut,
  input  wire logic second_in,
  input  wire logic gas_press,
  input  wire logic gas_permit,
  input  wire logic gas_over,
  input  wire logic oil_press,
  input  wire logic oil_over,
  input  wire logic oil_permit,
  input  wire logic redund,
  input  wire logic flame,
  input  wire logic redund_bad,
  // pins
  output logic      valve_closed_contact,
  output logic      second_contact,
  output logic      gas_low_ok,
  output logic      gas_high_trip,
  output logic      oil_low_ok,
  output logic      oil_high_trip,
  output logic      oil_start_permit,
  output logic      flame_contact
);
  assign valve_closed_contact = valve_shut;
  assign second_contact = second_in;
  assign gas_low_ok = gas_press & gas_permit;
  assign gas_high_trip = gas_over;
  assign oil_low_ok = oil_press;
  assign oil_high_trip = oil_over;
  // broken redundancy contact only on command
  assign oil_start_permit = redund ? (~flame ^ redund_bad) : oil_permit;
  assign flame_contact = flame;
endmodule // pin_field_model
`default_nettype wire

/* verification/burner_input_supervisor_bench.sv */
// self-checking bench for the burner input supervisor
// assumes one clock, short tick parameter, field model on the pins
`timescale 1ns/100ps
`default_nettype none
`include "burner_input_supervisor_regs.vh"

module burner_input_supervisor_bench;
  localparam int TK = 10;
  logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, phase;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        fuel_gas, gas_pilot, heavy_oil, preignition, first_safety_started;
  logic        safety_time, second_safety_done, vs, s2, gp, gperm, gov, op, oov, operm;
  logic        red, fl, bad, valve_closed_contact, second_contact, gas_low_ok;
  logic        gas_high_trip, oil_low_ok, oil_high_trip, oil_start_permit, flame_contact;
  logic        start_block_q, start_block_msg_q, shutdown_q, safety_shutdown_q, gas_shortage_q;
  logic [7:0]  tbl [8] = '{8'h0C, 8'h14, 8'h26, 8'h36, 8'h3C, 8'h48, 8'h4E, 8'h28};
  integer      failures, checked, cyc_n, seed, m, i, t, c;

  burner_input_supervisor #(.TICK_CYCLES(TK), .TICK_W(20)) u_dut (.*);
  pin_field_model u_pins (
    .valve_shut(vs), .second_in(s2), .gas_press(gp), .gas_permit(gperm), .gas_over(gov),
    .oil_press(op), .oil_over(oov), .oil_permit(operm), .redund(red), .flame(fl),
    .redund_bad(bad), .valve_closed_contact, .second_contact, .gas_low_ok, .gas_high_trip,
    .oil_low_ok, .oil_high_trip, .oil_start_permit, .flame_contact);

  // ----
  // tasks
  // ----
  task automatic test_done();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n = n + 1;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    chk("bus_ack", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic put(input logic [7:0] p, input logic [6:0] s, input logic [10:0] q);
    @(posedge clk_sys);
    phase <= p;
    {fuel_gas, gas_pilot, heavy_oil, preignition, first_safety_started, safety_time,
     second_safety_done} <= s;
    {vs, s2, gp, gperm, gov, op, oov, operm, red, fl, bad} <= q;
  endtask
  // expected {block, shutdown, safety, shortage}; 5 cycles cover sync and flop
  task automatic rx(input logic [7:0] p, input logic [6:0] s, input logic [10:0] q,
                    input logic [3:0] e);
    put(p, s, q);
    repeat (5) @(posedge clk_sys);
    chk("reactions", {28'h0, e},
        {28'h0, start_block_q, shutdown_q, safety_shutdown_q, gas_shortage_q});
  endtask
  function automatic logic [3:0] cexp(input int md, input logic g, input logic [7:0] p,
                                      input logic k);
    logic o;
    o = (md == 1) || (md == 0 && g) || (md == 2 && !g);
    if (p == `PH_STANDBY) return {!k, 3'h0};
    if (p == `PH_OPEN_A || p == `PH_OPEN_B) return {2'h0, k == o, 1'h0};
    if (p <= `PH_CLOSE_END1 || (p >= `PH_CLOSE_BEG2 && p <= `PH_CLOSE_END2)) return {2'h0, !k, 1'h0};
    return 4'h0;
  endfunction
  function automatic logic in_win(input logic [31:0] v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction

  // ----
  // clock, timeout, sequence
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 20000) begin
      failures = failures + 1;
      test_done();
    end
  end
  initial begin
    {seed, failures, checked, cyc_n, rst} = {32'd35, 96'h0, 1'b1};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'hF};
    put(8'h00, 7'h00, 11'h7A8);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wb(0, `ADR_CFG, 0);
    chk("cfg_reset", `RST_CFG, rd);
    wb(0, `ADR_REACT, 0);
    chk("react_reset", {16'h0, `RST_REACT}, rd);
    wb(0, `ADR_GAS_LIM, 0);
    chk("limit_reset", {16'h0, `RST_GAS_LIM}, rd);
    wb(0, 8'h20, 0);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    for (m = 0; m < 6; m++) begin
      wb(1, `ADR_CFG, m < 3 ? 32'h0A40 | (m + 1) : 32'h0A40 | ((m - 1) << 2));
      for (i = 0; i < 16; i++) begin
        c = $random(seed);
        rx(tbl[i % 8], {i[3], 6'h0}, m < 3 ? {c[0], 10'h3A8} : {1'b1, c[0], 9'h1A8},
           cexp(m % 3, i[3], tbl[i % 8], c[0]));
      end
    end
    $display("test contacts done");
    wb(1, `ADR_MSG_DLY, 32'h3);
    wb(1, `ADR_CFG, 32'h0A41);
    put(`PH_STANDBY, 7'h00, 11'h3A8);
    for (t = 0; start_block_msg_q !== 1'b1 && t < 100; t++) @(posedge clk_sys);
    chk("msg_delay", 32'h1, {31'h0, in_win(t, 2 * TK, 3 * TK + 10)});
    rx(`PH_STANDBY, 7'h00, 11'h7A8, 4'h0);
    $display("test message done");
    wb(1, `ADR_CFG, 32'h0A00);
    rx(`PH_PERMIT, 7'h40, 11'h6A8, 4'h1);
    rx(`PH_PERMIT, 7'h40, 11'h728, 4'h1);
    rx(8'h32, 7'h40, 11'h6A8, 4'h4);
    rx(8'h32, 7'h41, 11'h6A8, 4'h0);
    rx(8'h32, 7'h00, 11'h6A8, 4'h0);
    rx(8'h32, 7'h20, 11'h6A8, 4'h4);
    wb(1, `ADR_CFG, 32'h0A20);
    rx(8'h32, 7'h20, 11'h6A8, 4'h0);
    rx(8'h32, 7'h40, 11'h6A8, 4'h4);
    wb(1, `ADR_CFG, 32'h0A40);
    rx(8'h32, 7'h40, 11'h6A8, 4'h0);
    wb(1, `ADR_CFG, 32'h0A00);
    wb(1, `ADR_REACT, 32'h5);
    rx(8'h32, 7'h46, 11'h7A8, 4'h0);
    put(8'h32, 7'h46, 11'h6A8);
    for (t = 0; shutdown_q !== 1'b1 && t < 400; t++) @(posedge clk_sys);
    chk("react_delay", 32'h1, {31'h0, in_win(t, (`REACT_MIN_TICKS - 1) * TK,
        `REACT_MIN_TICKS * TK + 10)});
    $display("test gas low done");
    wb(1, `ADR_CFG, 32'h0EC0);
    rx(8'h32, 7'h44, 11'h7E8, 4'h2);
    rx(8'h32, 7'h40, 11'h7E8, 4'h0);
    rx(8'h32, 7'h00, 11'h7B8, 4'h2);
    rx(8'h32, 7'h40, 11'h7B8, 4'h0);
    wb(1, `ADR_CFG, 32'h0840);
    rx(8'h32, 7'h08, 11'h788, 4'h2);
    wb(1, `ADR_CFG, 32'h0940);
    rx(8'h32, 7'h08, 11'h788, 4'h0);
    rx(8'h32, 7'h04, 11'h788, 4'h2);
    wb(1, `ADR_CFG, 32'h0240);
    rx(`PH_PERMIT, 7'h00, 11'h7A0, 4'h4);
    rx(`PH_PERMIT, 7'h40, 11'h7A0, 4'h0);
    wb(1, `ADR_CFG, 32'h1240);
    c = $random(seed);
    rx(`PH_PERMIT, 7'h00, {9'h1EB, c[0], 1'b0}, 4'h0);
    rx(`PH_PERMIT, 7'h00, {9'h1EB, c[0], 1'b1}, 4'h2);
    wb(1, `ADR_CFG, 32'h0A44);
    rx(8'h32, 7'h40, 11'h5A8, 4'h4);
    rx(8'h32, 7'h41, 11'h5A8, 4'h0);
    wb(0, `ADR_CAUSE, 0);
    chk("cause_sticky", 32'h10, rd & 32'h10);
    wb(1, `ADR_CAUSE, 32'h3FF);
    wb(0, `ADR_CAUSE, 0);
    chk("cause_clear", 32'h0, rd);
    wb(0, `ADR_STATUS, 0);
    chk("status", 32'h5500, rd);
    $display("test pressure done");
    test_done();
  end
endmodule // burner_input_supervisor_bench
`default_nettype wire
